// [design/mlpc_counters.sv]
`timescale 1ns/100ps
`include "mlpc_consts.svh"

module mlpc_counters #(
    parameter int CTR_W = `MLPC_CTR_W
)(
    // Clock and reset
    input  wire logic                 i_clk_sys,
    input  wire logic                 i_arst_n,
    // Global control, from the same clock domain
    input  wire logic                 i_global_enable,
    input  wire logic                 i_global_freeze,
    // Software access
    input  wire mlpc_pkg::mlpc_wr_s   i_wr,
    // Bridge events
    input  wire mlpc_pkg::mlpc_evt_s  i_evt,
    // Counter and control readback
    output logic [3:0][CTR_W-1:0]     o_link_event_counter,
    output mlpc_pkg::mlpc_ctl_s [3:0] o_link_event_control,
    output logic                      o_counting
);
    import mlpc_pkg::*;

    logic [3:0][CTR_W-1:0] ctr_r;
    logic [3:0][CTR_W-1:0] ctr_nxt;
    mlpc_ctl_s [3:0]       ctl_r;
    mlpc_ctl_s [3:0]       ctl_nxt;
    logic [3:0][7:0]       inc;
    mlpc_run_e             run_r;
    mlpc_run_e             run_nxt;
    logic                  cnt_en_r;
    logic                  cnt_en_nxt;
    logic [3:0][7:0]       inc_r;
    logic [3:0][7:0]       inc_nxt;

    // One selector per counter; each knows its own index for the restrictions.
    for (genvar g = 0; g < `MLPC_NUM_CTRS; g++)
    begin : g_sel
        mlpc_event_select #(
            .CTR_IDX (2'(g))
        ) u_sel (
            .i_ctl (ctl_r[g]),
            .i_evt (i_evt),
            .o_inc (inc[g])
        );
    end

    // Global run state: enable starts counting, freeze holds values.
    always_comb
    begin
        run_nxt = run_r;
        unique case (run_r)
            MLPC_RUN_IDLE:   if (i_global_enable && !i_global_freeze) run_nxt = MLPC_RUN_COUNT;
            MLPC_RUN_COUNT:
                if (!i_global_enable)
                    run_nxt = MLPC_RUN_IDLE;
                else if (i_global_freeze)
                    run_nxt = MLPC_RUN_FROZEN;
            MLPC_RUN_FROZEN:
                if (!i_global_enable)
                    run_nxt = MLPC_RUN_IDLE;
                else if (!i_global_freeze)
                    run_nxt = MLPC_RUN_COUNT;
        endcase
        // Enable and increments are staged one cycle to ease timing at 200 MHz;
        // this is why ticks trail the global control by a couple of cycles.
        cnt_en_nxt = (run_nxt == MLPC_RUN_COUNT);
        inc_nxt    = inc;
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            run_r    <= MLPC_RUN_IDLE;
            cnt_en_r <= 1'b0;
            inc_r    <= '0;
        end
        else
        begin
            run_r    <= run_nxt;
            cnt_en_r <= cnt_en_nxt;
            inc_r    <= inc_nxt;
        end
    end

    // Counter and control next values; a software write wins over counting.
    always_comb
    begin
        ctr_nxt = ctr_r;
        ctl_nxt = ctl_r;
        for (int i = 0; i < `MLPC_NUM_CTRS; i++)
        begin
            if (cnt_en_r)
                ctr_nxt[i] = ctr_r[i] + CTR_W'(inc_r[i]);
            if (i_wr.ctr_we && i_wr.idx == 2'(i))
                ctr_nxt[i] = i_wr.wdata[CTR_W-1:0];
            if (i_wr.ctl_we && i_wr.idx == 2'(i))
                ctl_nxt[i] = {16'h0000, i_wr.wdata[`MLPC_CTL_MASK_MSB:0]};
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            ctr_r <= '0;
            ctl_r <= '0;
        end
        else
        begin
            ctr_r <= ctr_nxt;
            ctl_r <= ctl_nxt;
        end
    end

    // Outputs straight from flip-flops.
    assign o_link_event_counter = ctr_r;
    assign o_link_event_control = ctl_r;
    assign o_counting           = cnt_en_r;

    // Helper: counter 0 value seen from the previous cycle.
    logic [CTR_W-1:0] ctr0_prev_r;
    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
            ctr0_prev_r <= '0;
        else
            ctr0_prev_r <= ctr_r[0];
    end

    sequence s_tick_cfg;
        ctl_r[0].code == `MLPC_EV_CLOCK_TICK && cnt_en_r && !i_wr.ctr_we && !i_wr.ctl_we &&
            $stable(ctl_r[0].code);
    endsequence

    property p_tick;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        s_tick_cfg |=> ctr_r[0] == $past(ctr_r[0]) + 1;
    endproperty
    a_tick: assert property (p_tick) else $error("tick event did not add one");

    property p_flq_ctr1;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        (ctl_r[1].code >= `MLPC_EV_FLQ_OCC_LO && ctl_r[1].code <= `MLPC_EV_FLQ_OCC_HI) |-> inc[1] == 8'h00;
    endproperty
    a_flq_ctr1: assert property (p_flq_ctr1) else $error("flow queue occupancy on counter 1");

    property p_held_ctr3;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        (ctl_r[3].code == `MLPC_EV_HELD || ctl_r[3].code == `MLPC_EV_BYPASS) |-> inc[3] == 8'h00;
    endproperty
    a_held_ctr3: assert property (p_held_ctr3) else $error("restricted event on counter 3");

    property p_mask_zero;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        (ctl_r[2].code == `MLPC_EV_ARB_MISC && (ctl_r[2].umask & i_evt.arb_misc_event) == 8'h00) |->
            inc[2] == 8'h00;
    endproperty
    a_mask_zero: assert property (p_mask_zero) else $error("empty mask still counted");

    property p_agent_crd;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        ctl_r[0].code == `MLPC_EV_AGENT_CRD |->
            inc[0] == {7'h00, |(i_evt.agent_addr_credit_empty & ctl_r[0].umask[3:0])};
    endproperty
    a_agent_crd: assert property (p_agent_crd) else $error("agent credit empty miscounted");

    property p_write_load;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        i_wr.ctr_we |=> ctr_r[$past(i_wr.idx)] == $past(i_wr.wdata[CTR_W-1:0]);
    endproperty
    a_write_load: assert property (p_write_load) else $error("counter write not loaded");

    property p_frozen;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        (!cnt_en_r && !i_wr.ctr_we) |=> ctr_r[0] == ctr0_prev_r;
    endproperty
    a_frozen: assert property (p_frozen) else $error("counter moved while stopped");

    property p_enable_lag;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        (i_global_enable && !i_global_freeze)[*3] |-> cnt_en_r;
    endproperty
    a_enable_lag: assert property (p_enable_lag) else $error("counting started too late");

    property p_occ;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        ctl_r[1].code == `MLPC_EV_OCC_VN0 |-> inc[1] == i_evt.ingress_occ[0];
    endproperty
    a_occ: assert property (p_occ) else $error("occupancy not accumulated");

    // Control writes keep only code and mask, so the upper half always reads zero.
    property p_ctl_load;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        i_wr.ctl_we |=> ctl_r[$past(i_wr.idx)] == {16'h0000, $past(i_wr.wdata[`MLPC_CTL_MASK_MSB:0])};
    endproperty
    a_ctl_load: assert property (p_ctl_load) else $error("control write not loaded");

    property p_flq_ctr0;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        (ctl_r[0].code >= `MLPC_EV_FLQ_OCC_LO && ctl_r[0].code <= `MLPC_EV_FLQ_OCC_HI) |->
            inc[0] == i_evt.flq_occ[ctl_r[0].code[1:0]];
    endproperty
    a_flq_ctr0: assert property (p_flq_ctr0) else $error("flow queue occupancy not added on counter 0");

    property p_flq_evt;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        (ctl_r[1].code >= `MLPC_EV_FLQ_EVT_LO && ctl_r[1].code <= `MLPC_EV_FLQ_EVT_HI) |->
            inc[1] == {7'h00, i_evt.flowq_event[ctl_r[1].code[1:0]]};
    endproperty
    a_flq_evt: assert property (p_flq_evt) else $error("flow queue event miscounted");

    property p_pcie_crd;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        ctl_r[3].code == `MLPC_EV_PCIE_CRD |->
            inc[3] == {7'h00, |(i_evt.pcie_data_credit_empty & ctl_r[3].umask)};
    endproperty
    a_pcie_crd: assert property (p_pcie_crd) else $error("data credit empty miscounted");

    property p_dir_util;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        ctl_r[1].code == `MLPC_EV_DIR_UTIL |-> inc[1] == {7'h00, i_evt.direct_utility_sent};
    endproperty
    a_dir_util: assert property (p_dir_util) else $error("direct utility send miscounted");

    property p_dir_core;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        ctl_r[2].code == `MLPC_EV_DIR_CORE |-> inc[2] == {7'h00, i_evt.direct_core_sent};
    endproperty
    a_dir_core: assert property (p_dir_core) else $error("direct core send miscounted");

    property p_multislot;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        ctl_r[2].code == `MLPC_EV_MULTISLOT |->
            inc[2] == {7'h00, |(i_evt.multislot_flit_received & ctl_r[2].umask[5:0])};
    endproperty
    a_multislot: assert property (p_multislot) else $error("multi slot flit miscounted");

    property p_bypass_ctr2;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        ctl_r[2].code == `MLPC_EV_BYPASS |->
            inc[2] == {7'h00, |(i_evt.ingress_bypass_event & ctl_r[2].umask[3:0])};
    endproperty
    a_bypass_ctr2: assert property (p_bypass_ctr2) else $error("bypass not counted on counter 2");

    property p_lost_vn1;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        ctl_r[3].code == `MLPC_EV_LOST_VN1 |->
            inc[3] == 8'($countones(i_evt.arb_lost_second_net & ctl_r[3].umask[6:0]));
    endproperty
    a_lost_vn1: assert property (p_lost_vn1) else $error("lost arbitration miscounted");

    property p_arb_misc;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        ctl_r[0].code == `MLPC_EV_ARB_MISC |->
            inc[0] == {7'h00, |(i_evt.arb_misc_event & ctl_r[0].umask)};
    endproperty
    a_arb_misc: assert property (p_arb_misc) else $error("arbitration misc miscounted");

    property p_nocrd_arb;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        ctl_r[2].code == `MLPC_EV_NOCRD_VN0 |->
            inc[2] == 8'($countones(i_evt.arb_blocked_no_credit & ctl_r[2].umask[6:0]));
    endproperty
    a_nocrd_arb: assert property (p_nocrd_arb) else $error("blocked arbitration miscounted");

    property p_credit_used;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        ctl_r[3].code == `MLPC_EV_CRD_USED1 |-> inc[3] == i_evt.credit_used[1];
    endproperty
    a_credit_used: assert property (p_credit_used) else $error("credit use not accumulated");

    property p_unknown;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        ctl_r[0].code == 8'h00 |-> inc[0] == 8'h00;
    endproperty
    a_unknown: assert property (p_unknown) else $error("unknown event code counted");

    // Freeze or a dropped enable must stop counting at the very next edge.
    property p_stop;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        (i_global_freeze || !i_global_enable) |=> !cnt_en_r;
    endproperty
    a_stop: assert property (p_stop) else $error("counting went on after stop");

    // Each counting cycle adds exactly the staged increment of the cycle before.
    sequence s_count_step;
        cnt_en_r && !i_wr.ctr_we;
    endsequence

    property p_count_step;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        s_count_step |=> ctr_r[1] == $past(ctr_r[1]) + CTR_W'($past(inc_r[1]));
    endproperty
    a_count_step: assert property (p_count_step) else $error("staged increment not added");

endmodule

// [pkg/mlpc_consts.svh]
`ifndef MLPC_CONSTS_SVH
`define MLPC_CONSTS_SVH

// Counter geometry.
`define MLPC_NUM_CTRS        4
`define MLPC_CTR_W           48
`define MLPC_CTL_W           32
`define MLPC_OCC_W           8

// Control word fields.
`define MLPC_CTL_EVT_LSB     0
`define MLPC_CTL_EVT_MSB     7
`define MLPC_CTL_MASK_LSB    8
`define MLPC_CTL_MASK_MSB    15
`define MLPC_CTL_RESET       32'h0000_0000

// Event codes.
`define MLPC_EV_CLOCK_TICK   8'h01
`define MLPC_EV_FLQ_OCC_LO   8'h1c
`define MLPC_EV_FLQ_OCC_HI   8'h1f
`define MLPC_EV_AGENT_CRD    8'h22
`define MLPC_EV_PCIE_CRD     8'h23
`define MLPC_EV_DIR_UTIL     8'h2a
`define MLPC_EV_DIR_CORE     8'h2b
`define MLPC_EV_FLQ_EVT_LO   8'h2c
`define MLPC_EV_FLQ_EVT_HI   8'h2f
`define MLPC_EV_MULTISLOT    8'h3e
`define MLPC_EV_BYPASS       8'h40
`define MLPC_EV_INS_VN0      8'h41
`define MLPC_EV_INS_VN1      8'h42
`define MLPC_EV_NE_VN0       8'h43
`define MLPC_EV_NE_VN1       8'h44
`define MLPC_EV_OCC_VN0      8'h45
`define MLPC_EV_OCC_VN1      8'h46
`define MLPC_EV_NOCRD_VN0    8'h47
`define MLPC_EV_LOST_VN0     8'h4b
`define MLPC_EV_LOST_VN1     8'h4c
`define MLPC_EV_ARB_MISC     8'h4d
`define MLPC_EV_PMISS_VN0    8'h4e
`define MLPC_EV_PMISS_VN1    8'h4f
`define MLPC_EV_HELD         8'h50
`define MLPC_EV_CRD_USED0    8'h5b
`define MLPC_EV_CRD_USED1    8'h5c
`define MLPC_EV_NOCRD0       8'h5d
`define MLPC_EV_NOCRD1       8'h5e

// Counter 3 is the only one barred from the restricted ingress events.
`define MLPC_LAST_CTR_IDX    2'h3

`endif

// [pkg/mlpc_pkg.sv]
package mlpc_pkg;

    // One counter's control word split into its fields.
    typedef struct packed {
        logic [15:0] rsvd;
        logic [7:0]  umask;
        logic [7:0]  code;
    } mlpc_ctl_s;

    // Per-cycle event inputs coming from the bridge datapath.
    typedef struct packed {
        logic [3:0][7:0] flq_occ;
        logic [3:0]      agent_addr_credit_empty;
        logic [7:0]      pcie_data_credit_empty;
        logic            direct_utility_sent;
        logic            direct_core_sent;
        logic [3:0]      flowq_event;
        logic [5:0]      multislot_flit_received;
        logic [3:0]      ingress_bypass_event;
        logic [1:0]      ingress_insert;
        logic [1:0]      ingress_not_empty;
        logic [1:0][7:0] ingress_occ;
        logic [6:0]      arb_blocked_no_credit;
        logic [6:0]      arb_lost_first_net;
        logic [6:0]      arb_lost_second_net;
        logic [7:0]      arb_misc_event;
        logic [1:0][7:0] packing_miss_event;
        logic [7:0]      message_held_event;
        logic [1:0][7:0] credit_used;
        logic [1:0]      credit_none;
    } mlpc_evt_s;

    // Software write into one counter or control register.
    typedef struct packed {
        logic        ctl_we;
        logic        ctr_we;
        logic [1:0]  idx;
        logic [47:0] wdata;
    } mlpc_wr_s;

    typedef enum logic [1:0] {
        MLPC_RUN_IDLE,
        MLPC_RUN_COUNT,
        MLPC_RUN_FROZEN
    } mlpc_run_e;

endpackage

// [design/mlpc_event_select.sv]
`timescale 1ns/100ps
`include "mlpc_consts.svh"

// Turns one control word and the event vector into an increment for one counter.
module mlpc_event_select #(
    parameter logic [1:0] CTR_IDX = 2'h0
)(
    // Selection
    input  wire mlpc_pkg::mlpc_ctl_s i_ctl,
    input  wire mlpc_pkg::mlpc_evt_s i_evt,
    // Result
    output logic [7:0]               o_inc
);
    import mlpc_pkg::*;

    // Counts the set bits of a mask-qualified vector, used for multi-hit classes.
    function automatic logic [7:0] pop8(input logic [7:0] v);
        logic [7:0] n;
        n = 8'h00;
        for (int i = 0; i < 8; i++)
            n = n + {7'h00, v[i]};
        return n;
    endfunction

    // Reduces a masked vector to one hit when any enabled subevent fires.
    function automatic logic [7:0] any8(input logic [7:0] v, input logic [7:0] m);
        return {7'h00, |(v & m)};
    endfunction

    logic [7:0] m;
    logic       allowed;

    // Decodes the event code into an increment, with counter-index restrictions.
    always_comb
    begin
        m       = i_ctl.umask;
        o_inc   = 8'h00;
        allowed = 1'b1;
        if (i_ctl.code >= `MLPC_EV_FLQ_OCC_LO && i_ctl.code <= `MLPC_EV_FLQ_OCC_HI)
            allowed = (CTR_IDX == 2'h0);
        if (i_ctl.code == `MLPC_EV_BYPASS || i_ctl.code == `MLPC_EV_PMISS_VN0 ||
            i_ctl.code == `MLPC_EV_PMISS_VN1 || i_ctl.code == `MLPC_EV_HELD)
            allowed = (CTR_IDX != `MLPC_LAST_CTR_IDX);
        unique case (i_ctl.code)
            `MLPC_EV_CLOCK_TICK: o_inc = 8'h01;
            8'h1c, 8'h1d, 8'h1e, 8'h1f:
                o_inc = i_evt.flq_occ[i_ctl.code[1:0]];
            `MLPC_EV_AGENT_CRD: o_inc = any8({4'h0, i_evt.agent_addr_credit_empty}, m);
            // Bit 0 stands for the first two IO stacks sharing one credit.
            `MLPC_EV_PCIE_CRD:  o_inc = any8(i_evt.pcie_data_credit_empty, m);
            `MLPC_EV_DIR_UTIL:  o_inc = {7'h00, i_evt.direct_utility_sent};
            `MLPC_EV_DIR_CORE:  o_inc = {7'h00, i_evt.direct_core_sent};
            8'h2c, 8'h2d, 8'h2e, 8'h2f:
                o_inc = {7'h00, i_evt.flowq_event[i_ctl.code[1:0]]};
            `MLPC_EV_MULTISLOT: o_inc = any8({2'h0, i_evt.multislot_flit_received}, m);
            `MLPC_EV_BYPASS:    o_inc = any8({4'h0, i_evt.ingress_bypass_event}, m);
            `MLPC_EV_INS_VN0:   o_inc = {7'h00, i_evt.ingress_insert[0]};
            `MLPC_EV_INS_VN1:   o_inc = {7'h00, i_evt.ingress_insert[1]};
            `MLPC_EV_NE_VN0:    o_inc = {7'h00, i_evt.ingress_not_empty[0]};
            `MLPC_EV_NE_VN1:    o_inc = {7'h00, i_evt.ingress_not_empty[1]};
            `MLPC_EV_OCC_VN0:   o_inc = i_evt.ingress_occ[0];
            `MLPC_EV_OCC_VN1:   o_inc = i_evt.ingress_occ[1];
            `MLPC_EV_NOCRD_VN0: o_inc = pop8({1'b0, i_evt.arb_blocked_no_credit} & m);
            `MLPC_EV_LOST_VN0:  o_inc = pop8({1'b0, i_evt.arb_lost_first_net} & m);
            `MLPC_EV_LOST_VN1:  o_inc = pop8({1'b0, i_evt.arb_lost_second_net} & m);
            `MLPC_EV_ARB_MISC:  o_inc = any8(i_evt.arb_misc_event, m);
            `MLPC_EV_PMISS_VN0: o_inc = any8(i_evt.packing_miss_event[0], m);
            `MLPC_EV_PMISS_VN1: o_inc = any8(i_evt.packing_miss_event[1], m);
            `MLPC_EV_HELD:      o_inc = any8(i_evt.message_held_event, m);
            `MLPC_EV_CRD_USED0: o_inc = i_evt.credit_used[0];
            `MLPC_EV_CRD_USED1: o_inc = i_evt.credit_used[1];
            `MLPC_EV_NOCRD0:    o_inc = {7'h00, i_evt.credit_none[0]};
            `MLPC_EV_NOCRD1:    o_inc = {7'h00, i_evt.credit_none[1]};
            default:            o_inc = 8'h00;
        endcase
        if (!allowed)
            o_inc = 8'h00;
    end

endmodule

// [bench/tb_mesh_link_perf_counters.sv]
`timescale 1ns/100ps

module tb_mesh_link_perf_counters;
    import mlpc_pkg::*;

    // One expected result: k is 1 for a control readback, 2 for the counting flag, 0 for a counter.
    typedef struct packed {
        logic [1:0]  k;
        logic [1:0]  ix;
        logic [47:0] v;
    } mlpc_note_s;

    logic                  i_clk_sys       = 1'b0;
    logic                  i_arst_n        = 1'b0;
    logic                  i_global_enable = 1'b1;
    logic                  i_global_freeze = 1'b1;
    mlpc_wr_s              i_wr            = '0;
    mlpc_evt_s             i_evt           = '0;
    logic [3:0][47:0]      o_link_event_counter;
    mlpc_ctl_s [3:0]       o_link_event_control;
    logic                  o_counting;
    mlpc_note_s            q[$];
    mlpc_note_s            nt;
    event                  noted;
    logic                  mask_zero       = 1'b0;
    int                    n_mismatch      = 0;
    int                    checks          = 0;
    logic [7:0]            cl[$]           = '{8'h01, 8'h1c, 8'h1d, 8'h1e, 8'h1f, 8'h22, 8'h23, 8'h2a, 8'h2b,
        8'h2c, 8'h2d, 8'h2e, 8'h2f, 8'h3e, 8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h47, 8'h4b,
        8'h4c, 8'h4d, 8'h4e, 8'h4f, 8'h50, 8'h5b, 8'h5c, 8'h5d, 8'h5e, 8'h30, 8'h00};

    // Free-running system clock at 200 MHz.
    always #2.5 i_clk_sys = ~i_clk_sys;

    mlpc_counters #(.CTR_W(48)) i_dut (
        .i_clk_sys            (i_clk_sys),
        .i_arst_n             (i_arst_n),
        .i_global_enable      (i_global_enable),
        .i_global_freeze      (i_global_freeze),
        .i_wr                 (i_wr),
        .i_evt                (i_evt),
        .o_link_event_counter (o_link_event_counter),
        .o_link_event_control (o_link_event_control),
        .o_counting           (o_counting)
    );

    // Inputs always move a fixed 1 ns after the rising edge, clear of sampling.
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask

    // One write; the caller clears i_wr after a batch so it is never set twice in a step.
    task automatic wr(input logic c, input logic [1:0] ix, input logic [47:0] d);
        i_wr = '{ctl_we: c, ctr_we: !c, idx: ix, wdata: d};
        tick(1);
    endtask

    task automatic note(input logic [1:0] k, input logic [1:0] ix, input logic [47:0] v);
        q.push_back('{k, ix, v});
        -> noted;
    endtask

    task automatic cmp_ctr(input mlpc_note_s n);
        checks++;
        if (o_link_event_counter[n.ix] !== n.v)
        begin
            n_mismatch++;
            $display("BAD %0t counter %0d got %h want %h", $time, n.ix, o_link_event_counter[n.ix], n.v);
        end
    endtask

    task automatic cmp_ctl(input mlpc_note_s n);
        checks++;
        if (o_link_event_control[n.ix] !== n.v[31:0])
        begin
            n_mismatch++;
            $display("BAD %0t control %0d got %h want %h", $time, n.ix, o_link_event_control[n.ix], n.v[31:0]);
        end
    endtask

    task automatic cmp_run(input mlpc_note_s n);
        checks++;
        if (o_counting !== n.v[0])
        begin
            n_mismatch++;
            $display("BAD %0t counting got %b want %b", $time, o_counting, n.v[0]);
        end
    endtask

    // Per-cycle increment worked out independently from the event definitions.
    function automatic logic [7:0] inc(input int k, input mlpc_ctl_s c, input mlpc_evt_s e);
        logic [7:0] m;
        m = c.umask;
        case (c.code)
            8'h01: inc = 8'h01;
            8'h1c, 8'h1d, 8'h1e, 8'h1f: inc = e.flq_occ[c.code[1:0]];
            8'h22: inc = 8'(|(m[3:0] & e.agent_addr_credit_empty));
            8'h23: inc = 8'(|(m & e.pcie_data_credit_empty));
            8'h2a: inc = 8'(e.direct_utility_sent);
            8'h2b: inc = 8'(e.direct_core_sent);
            8'h2c, 8'h2d, 8'h2e, 8'h2f: inc = 8'(e.flowq_event[c.code[1:0]]);
            8'h3e: inc = 8'(|(m[5:0] & e.multislot_flit_received));
            8'h40: inc = 8'(|(m[3:0] & e.ingress_bypass_event));
            8'h41, 8'h42: inc = 8'(e.ingress_insert[c.code == 8'h42]);
            8'h43, 8'h44: inc = 8'(e.ingress_not_empty[c.code == 8'h44]);
            8'h45, 8'h46: inc = e.ingress_occ[c.code == 8'h46];
            8'h47: inc = 8'($countones(m[6:0] & e.arb_blocked_no_credit));
            8'h4b: inc = 8'($countones(m[6:0] & e.arb_lost_first_net));
            8'h4c: inc = 8'($countones(m[6:0] & e.arb_lost_second_net));
            8'h4d: inc = 8'(|(m & e.arb_misc_event));
            8'h4e, 8'h4f: inc = 8'(|(m & e.packing_miss_event[c.code == 8'h4f]));
            8'h50: inc = 8'(|(m & e.message_held_event));
            8'h5b, 8'h5c: inc = e.credit_used[c.code == 8'h5c];
            8'h5d, 8'h5e: inc = 8'(e.credit_none[c.code == 8'h5e]);
            default: inc = 8'h00;
        endcase
        if (c.code[7:2] == 6'h07 && k != 0) inc = 8'h00;
        if ((c.code inside {8'h40, 8'h4e, 8'h4f, 8'h50}) && k == 3) inc = 8'h00;
    endfunction

    // Program one code on all four counters, open a counting window of n cycles, note results.
    // One code on every counter also keeps mesh and non-mesh events from ever mixing.
    // The window is framed by freeze, so the pipeline latency cancels out of the count.
    task automatic run(input logic [7:0] code, input int n, input logic en, input logic w);
        mlpc_ctl_s   c[4];
        logic [47:0] s[4];
        logic [159:0] r;
        r = {$urandom, $urandom, $urandom, $urandom, $urandom};
        i_evt = r[$bits(mlpc_evt_s)-1:0];
        for (int k = 0; k < 4; k++)
        begin
            c[k] = '{16'h0000, mask_zero ? 8'h00 : 8'($urandom), code};
            s[k] = w ? 48'hffff_ffff_fffc : {16'($urandom), $urandom};
            wr(1'b1, 2'(k), {$urandom, c[k][15:0]});
            wr(1'b0, 2'(k), s[k]);
        end
        i_wr = '0;
        i_global_enable = en;
        tick(3);
        i_global_freeze = 1'b0;
        tick(n);
        note(2'd2, 2'h0, 48'(en));
        i_global_freeze = 1'b1;
        tick(4);
        note(2'd2, 2'h0, 48'h0);
        for (int k = 0; k < 4; k++)
        begin
            note(1'b1, 2'(k), {16'h0000, c[k]});
            note(1'b0, 2'(k), s[k] + 48'(n) * 48'(en ? inc(k, c[k], i_evt) : 8'h00));
        end
        i_global_enable = 1'b1;
    endtask

    task automatic print_verdict;
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Result watcher: each note is checked once the driver has let the outputs settle.
    initial
    begin
        forever
        begin
            @(noted);
            while (q.size() != 0)
            begin
                nt = q.pop_front();
                if (nt.k == 2'd1)
                    cmp_ctl(nt);
                else if (nt.k == 2'd2)
                    cmp_run(nt);
                else
                    cmp_ctr(nt);
            end
        end
    end

    // Watchdog sized well above the roughly 1500 cycles the sequence needs.
    initial
    begin
        #40000;
        n_mismatch++;
        print_verdict();
    end

    // Main sequence.
    initial
    begin
        void'($urandom(49567));
        tick(5);
        i_arst_n = 1'b1;
        for (int k = 0; k < 4; k++)
        begin
            note(1'b0, 2'(k), 48'h0);
            note(1'b1, 2'(k), 48'h0);
        end
        tick(1);
        run(8'h01, 6, 1'b1, 1'b1);
        run(8'h01, 6, 1'b0, 1'b0);
        // A second reset between runs must clear counters, controls and the counting flag again.
        i_arst_n = 1'b0;
        tick(2);
        i_arst_n = 1'b1;
        for (int k = 0; k < 4; k++)
        begin
            note(1'b0, 2'(k), 48'h0);
            note(1'b1, 2'(k), 48'h0);
        end
        note(2'd2, 2'h0, 48'h0);
        tick(1);
        // An empty mask must keep the masked arbitration misc (0x4d) and agent credit (0x22) events from counting.
        mask_zero = 1'b1;
        run(8'h4d, 6, 1'b1, 1'b0);
        run(8'h22, 6, 1'b1, 1'b0);
        mask_zero = 1'b0;
        repeat (2)
            foreach (cl[j]) run(cl[j], 6, 1'b1, 1'b0);
        tick(2);
        print_verdict();
    end
endmodule
